// ---- rtl/sst_pkg.sv ----
/*
 * Constants, register map and shared arithmetic for the sensor settle timer.
 * Assumes a single 200 MHz clock domain and a plain register port.
 */
package sst_pkg;

   // ==========================================================
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int CHAN_N = 3;
   localparam int CNT_W = 16;
   localparam int DIV_W = 10;
   localparam int TICK_W = 20;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_STAB0 = 8'h10;
   localparam logic [7:0] ADDR_STAB1 = 8'h11;
   localparam logic [7:0] ADDR_STAB2 = 8'h12;
   localparam logic [7:0] ADDR_DIV0 = 8'h14;
   localparam logic [7:0] ADDR_DIV1 = 8'h15;
   localparam logic [7:0] ADDR_DIV2 = 8'h16;
   localparam logic [7:0] ADDR_CTRL = 8'h20;
   localparam logic [7:0] ADDR_STAT = 8'h21;
   localparam logic [7:0] ADDR_MASK = 8'h22;
   localparam logic [7:0] ADDR_STATE = 8'h23;

   // ==========================================================
   // Field positions and reset values
   localparam int CTRL_WARN_EN_BIT = 0;
   localparam int STAT_START_BIT = 0;
   localparam int STAT_WARN_BIT = 1;
   localparam int STAT_W = 2;
   localparam int STATE_BUSY_BIT = 2;
   localparam logic [15:0] STAB_RESET = 16'h0000;
   localparam logic [9:0] DIV_RESET = 10'h000;
   localparam logic [1:0] MASK_RESET = 2'h0;
   localparam logic [1:0] STAT_RESET = 2'h0;
   localparam logic CTRL_RESET = 1'b0;

   // ==========================================================
   // Timing counts, in reference periods and clock cycles
   localparam logic [19:0] SHORT_PERIODS = 20'h00020;
   localparam int PERIOD_SHIFT = 4;
   localparam logic [15:0] SHORT_LIMIT = 16'h0001;
   localparam int START_LAT = 2;

   // Reference periods of settling for a programmed count.
   function automatic logic [19:0] eff_ticks(input logic [15:0] cnt);
      if (cnt <= SHORT_LIMIT)
         eff_ticks = SHORT_PERIODS;
      else
         eff_ticks = {cnt, 4'h0};
   endfunction : eff_ticks

   // A zero divider is not legal; it is run as divide by one.
   function automatic logic [9:0] eff_div(input logic [9:0] dv);
      eff_div = (dv == 10'h000) ? 10'h001 : dv;
   endfunction : eff_div

endpackage : sst_pkg

// ---- rtl/sst_timer_if.sv ----
/*
 * Signals between the settle controller and its timer core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface sst_timer_if;
   logic load;
   logic [19:0] ticks;
   logic [9:0] div;
   logic busy;
   logic tick;
   logic done;
   logic [19:0] remain;

   modport ctrl (
      output load, ticks, div,
      input busy, tick, done, remain
   );
   modport core (
      input load, ticks, div,
      output busy, tick, done, remain
   );
endinterface : sst_timer_if

// ---- rtl/sst_timer_core.sv ----
/*
 * Settle down-counter with its reference-period divider.
 * Assumes load is a one-cycle pulse and div is never zero.
 */
`timescale 1ns/1ps
module sst_timer_core (
   input wire logic clk_i,
   input wire logic rst_i,
   sst_timer_if.core tif
);
   logic [9:0] div_cnt_reg;
   logic [9:0] div_lat_reg;
   logic [19:0] remain_reg;
   logic busy_reg;
   logic done_reg;

   // ==========================================================
   // Reference divider and down counter
   // The divider restarts on load so the wait is an exact multiple of
   // the reference period rather than a partial first period.
   assign tif.tick = busy_reg && (div_cnt_reg == 10'h000);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_cnt_reg <= 10'h000;
         div_lat_reg <= 10'h001;
      end
      else if (tif.load)
      begin
         div_cnt_reg <= tif.div - 10'h001;
         div_lat_reg <= tif.div;
      end
      else if (tif.tick)
         div_cnt_reg <= div_lat_reg - 10'h001;
      else if (busy_reg)
         div_cnt_reg <= div_cnt_reg - 10'h001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         remain_reg <= 20'h00000;
         busy_reg <= 1'b0;
      end
      else if (tif.load)
      begin
         remain_reg <= tif.ticks;
         busy_reg <= 1'b1;
      end
      else if (tif.tick)
      begin
         remain_reg <= remain_reg - 20'h00001;
         if (remain_reg == 20'h00001)
            busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         done_reg <= 1'b0;
      else
         done_reg <= tif.tick && (remain_reg == 20'h00001);
   end

   assign tif.busy = busy_reg;
   assign tif.done = done_reg;
   assign tif.remain = remain_reg;

   load_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tif.load |=> remain_reg == $past(tif.ticks))
      else $error("Timer not loaded with effective count.");

endmodule : sst_timer_core

// ---- rtl/sst_settle_top.sv ----
/*
 * Sensor settle timer: settle counts, reference dividers, warning
 * control, event status with interrupt, and the settle sequence.
 * Assumes act_i and the register strobes come from logic on clk_i, and
 * amp_settled_i comes straight from the sensor front end, unsynchronised.
 */
// The implementer's own choice: the strobed register port.
// Overview of operation
// - Wait the channel's settle interval before conversion.
// - Unsettled amplitude at start warns, if enabled.
// - Count zero or one gives 32 periods.
// - Larger counts give count times 16 periods.
// - Counts are 16-bit, read/write, reset zero.
// - Channel 2 has its own independent count.
// - Reference period is clock over channel divider.
`timescale 1ns/1ps
module sst_settle_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic act_i,
   input wire logic [1:0] act_chan_i,
   input wire logic amp_settled_i,
   output logic busy_o,
   output logic conv_start_o,
   output logic [1:0] conv_chan_o,
   output logic amp_warn_o,
   output logic irq_o
);
   typedef enum logic [1:0] {
      SST_IDLE = 2'b01,
      SST_SETTLE = 2'b10
   } sst_state_t;

   sst_state_t state_reg;
   sst_timer_if tif ();

   logic [15:0] stabilize_reg [0:2];
   logic [9:0] divider_reg [0:2];
   logic warn_en_reg;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic [15:0] rdata_reg;
   logic [1:0] chan_reg;
   logic conv_start_reg;
   logic amp_warn_reg;
   logic amp_s1_reg;
   logic amp_s2_reg;
   logic amp_s3_reg;
   logic amp_ok_reg;
   logic accept;
   logic [1:0] events;
   logic [1:0] clear_bits;
   logic [1:0] sel_chan;

   // Register slot for an address, or CHAN_N when it is no count slot.
   function automatic logic [1:0] stab_slot(input logic [7:0] a);
      unique case (a)
         sst_pkg::ADDR_STAB0: stab_slot = 2'h0;
         sst_pkg::ADDR_STAB1: stab_slot = 2'h1;
         sst_pkg::ADDR_STAB2: stab_slot = 2'h2;
         default: stab_slot = 2'h3;
      endcase
   endfunction : stab_slot

   function automatic logic [1:0] div_slot(input logic [7:0] a);
      unique case (a)
         sst_pkg::ADDR_DIV0: div_slot = 2'h0;
         sst_pkg::ADDR_DIV1: div_slot = 2'h1;
         sst_pkg::ADDR_DIV2: div_slot = 2'h2;
         default: div_slot = 2'h3;
      endcase
   endfunction : div_slot

   // ==========================================================
   // Settle and divider registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < sst_pkg::CHAN_N; i++)
         begin
            stabilize_reg[i] <= sst_pkg::STAB_RESET;
            divider_reg[i] <= sst_pkg::DIV_RESET;
         end
      end
      else if (wr_i)
      begin
         if (stab_slot(addr_i) != 2'h3)
            stabilize_reg[stab_slot(addr_i)] <= wdata_i;
         if (div_slot(addr_i) != 2'h3)
            divider_reg[div_slot(addr_i)] <= wdata_i[9:0];
      end
   end

   // ==========================================================
   // Control, mask and event status
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         warn_en_reg <= sst_pkg::CTRL_RESET;
         mask_reg <= sst_pkg::MASK_RESET;
      end
      else if (wr_i)
      begin
         if (addr_i == sst_pkg::ADDR_CTRL)
            warn_en_reg <= wdata_i[sst_pkg::CTRL_WARN_EN_BIT];
         if (addr_i == sst_pkg::ADDR_MASK)
            mask_reg <= wdata_i[1:0];
      end
   end

   // An event in the same cycle as its write-one-to-clear survives.
   always_comb
   begin
      events = 2'h0;
      events[sst_pkg::STAT_START_BIT] = conv_start_reg;
      events[sst_pkg::STAT_WARN_BIT] = amp_warn_reg;
      clear_bits = (wr_i && addr_i == sst_pkg::ADDR_STAT) ?
         wdata_i[1:0] : 2'h0;
      status_next = (status_reg & ~clear_bits) | events;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_reg <= sst_pkg::STAT_RESET;
      else
         status_reg <= status_next;
   end

   assign irq_o = |(status_reg & mask_reg);

   // ==========================================================
   // Read port
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdata_reg <= 16'h0000;
      else if (!rd_i)
         rdata_reg <= 16'h0000;
      else if (stab_slot(addr_i) != 2'h3)
         rdata_reg <= stabilize_reg[stab_slot(addr_i)];
      else if (div_slot(addr_i) != 2'h3)
         rdata_reg <= {6'h00, divider_reg[div_slot(addr_i)]};
      else if (addr_i == sst_pkg::ADDR_CTRL)
         rdata_reg <= {15'h0000, warn_en_reg};
      else if (addr_i == sst_pkg::ADDR_STAT)
         rdata_reg <= {14'h0000, status_reg};
      else if (addr_i == sst_pkg::ADDR_MASK)
         rdata_reg <= {14'h0000, mask_reg};
      else if (addr_i == sst_pkg::ADDR_STATE)
         rdata_reg <= {13'h0000, state_reg == SST_SETTLE, chan_reg};
      else
         rdata_reg <= 16'h0000;
   end

   assign rdata_o = rdata_reg;

   // ==========================================================
   // Amplitude-settled input synchroniser
   // The level is taken only once two later stages agree, so a sample
   // caught mid-transition never reaches the warning decision.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         amp_s1_reg <= 1'b0;
         amp_s2_reg <= 1'b0;
         amp_s3_reg <= 1'b0;
         amp_ok_reg <= 1'b0;
      end
      else
      begin
         amp_s1_reg <= amp_settled_i;
         amp_s2_reg <= amp_s1_reg;
         amp_s3_reg <= amp_s2_reg;
         if (amp_s2_reg == amp_s3_reg)
            amp_ok_reg <= amp_s3_reg;
      end
   end

   // ==========================================================
   // Settle sequence
   // Channel 3 has no count here, so requests for it are dropped; so is
   // any request while a wait is already running.
   assign accept = act_i && (act_chan_i != 2'h3) && (state_reg == SST_IDLE);

   assign tif.load = accept;
   // Channel 3 never indexes the arrays; accept drops it anyway.
   assign sel_chan = (act_chan_i == 2'h3) ? 2'h0 : act_chan_i;
   assign tif.ticks =
      sst_pkg::eff_ticks(stabilize_reg[sel_chan]);
   assign tif.div = sst_pkg::eff_div(divider_reg[sel_chan]);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= SST_IDLE;
         chan_reg <= 2'h0;
      end
      else
      begin
         unique case (state_reg)
            SST_IDLE:
               if (accept)
               begin
                  state_reg <= SST_SETTLE;
                  chan_reg <= act_chan_i;
               end
            SST_SETTLE:
               if (tif.done)
                  state_reg <= SST_IDLE;
            default:
               state_reg <= SST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         conv_start_reg <= 1'b0;
         amp_warn_reg <= 1'b0;
      end
      else
      begin
         conv_start_reg <= (state_reg == SST_SETTLE) && tif.done;
         amp_warn_reg <= (state_reg == SST_SETTLE) && tif.done &&
            !amp_ok_reg && warn_en_reg;
      end
   end

   assign busy_o = (state_reg == SST_SETTLE);
   assign conv_start_o = conv_start_reg;
   assign conv_chan_o = chan_reg;
   assign amp_warn_o = amp_warn_reg;

   sst_timer_core u_core (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tif(tif)
   );

   // ==========================================================
   // Checking helpers
   // Nothing in the datapath reads these, so synthesis trims them; they
   // keep the timing checks independent of the timer core's own counters.
   logic [31:0] elapsed_reg;
   logic [15:0] cnt_lat_reg;
   logic [9:0] div_lat_reg;
   logic [9:0] gap_reg;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         elapsed_reg <= 32'h00000000;
         cnt_lat_reg <= 16'h0000;
         div_lat_reg <= 10'h001;
         gap_reg <= 10'h000;
      end
      else
      begin
         elapsed_reg <= accept ? 32'h00000001 : elapsed_reg + 32'h00000001;
         if (accept)
         begin
            cnt_lat_reg <= stabilize_reg[sel_chan];
            div_lat_reg <= sst_pkg::eff_div(divider_reg[sel_chan]);
         end
         gap_reg <= (accept || tif.tick) ? 10'h001 : gap_reg + 10'h001;
      end
   end

   no_early_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      accept |=> !conv_start_o [*8])
      else $error("Conversion started before settling.");

   amp_warn_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy_o && tif.done && !amp_ok_reg && warn_en_reg)
      |=> amp_warn_o && conv_start_o)
      else $error("Missing amplitude warning at conversion start.");

   warn_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      amp_warn_o |-> conv_start_o && $past(warn_en_reg)
      && !$past(amp_ok_reg))
      else $error("Amplitude warning without cause.");

   short_settle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_start_o && cnt_lat_reg <= 16'h0001) |->
      elapsed_reg == 32'd32 * {22'h000000, div_lat_reg} + 32'd2)
      else $error("Short count did not settle for 32 periods.");

   long_settle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_start_o && cnt_lat_reg > 16'h0001) |->
      elapsed_reg == {16'h0000, cnt_lat_reg} * 32'd16
      * {22'h000000, div_lat_reg} + 32'd2)
      else $error("Settle interval is not count times 16 periods.");

   count_rw_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_i && addr_i == sst_pkg::ADDR_STAB0) ##1 (rd_i && !wr_i
      && addr_i == sst_pkg::ADDR_STAB0) |=> rdata_o == $past(wdata_i, 2))
      else $error("Settle count readback mismatch.");

   chan2_isolate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_i && addr_i == sst_pkg::ADDR_STAB2) |=> $stable(stabilize_reg[0])
      && $stable(stabilize_reg[1]))
      else $error("Channel 2 write disturbed another channel.");

   ref_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tif.tick |-> gap_reg == div_lat_reg)
      else $error("Reference period differs from divider.");

   busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy_o && !tif.done) |=> busy_o)
      else $error("Settle wait ended before the timer expired.");

   conv_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_start_o |=> !conv_start_o)
      else $error("Conversion start held for more than one cycle.");

   busy_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (busy_o && act_i) |=> conv_chan_o == $past(conv_chan_o))
      else $error("Request taken while a settle wait was running.");

   warn_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !warn_en_reg |=> !amp_warn_o)
      else $error("Amplitude warning raised while reporting is off.");

   count_reset_a: assert property (@(posedge clk_i)
      $fell(rst_i) |-> stabilize_reg[0] == sst_pkg::STAB_RESET
      && stabilize_reg[1] == sst_pkg::STAB_RESET
      && stabilize_reg[2] == sst_pkg::STAB_RESET)
      else $error("Settle count not zero after reset.");

endmodule : sst_settle_top

// ---- tb/sst_tank_model.sv ----
/*
 * Behavioural model of the resonant sensor tank at the far side.
 * Assumes the settle wait (busy) marks when excitation starts.
 */
`timescale 1ns/1ps
module sst_tank_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic drive_i,
   input wire logic [15:0] settle_cyc_i,
   output logic amp_settled_o
);
   // ==========================================================
   // Amplitude build-up
   logic drive_reg;
   logic [15:0] age_reg;

   // A fresh excitation collapses the amplitude; it then takes
   // settle_cyc_i cycles to build up, which is what may trigger a warning.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         drive_reg <= 1'b0;
         age_reg <= 16'h0000;
         amp_settled_o <= 1'b0;
      end
      else
      begin
         drive_reg <= drive_i;
         if (drive_i && !drive_reg)
         begin
            age_reg <= 16'h0000;
            amp_settled_o <= 1'b0;
         end
         else if (age_reg != settle_cyc_i)
            age_reg <= age_reg + 16'h0001;
         else
            amp_settled_o <= 1'b1;
      end
   end
endmodule : sst_tank_model

// ---- tb/sst_settle_top_tb.sv ----
/*
 * Self-checking bench for the sensor settle timer.
 * Assumes the design package and the tank model are compiled first.
 */
`timescale 1ns/1ps
module sst_settle_top_tb;
   // ==========================================================
   // Signals and model state
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic act_i = 1'b0;
   logic [1:0] act_chan_i = 2'h0;
   logic amp_settled_i;
   logic [15:0] rdata_o;
   logic busy_o, conv_start_o, amp_warn_o, irq_o;
   logic [1:0] conv_chan_o;
   logic [15:0] settle_cyc = 16'h0004;
   int bad_count = 0;
   int check_count = 0;
   integer seed = 32'hDDBD04C2;
   int cnt_m [3];
   int mask_m = 0;
   int stat_m = 0;
   int last_ch = 0;

   sst_settle_top sst_settle_top_i (.clk_i(clk_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .act_i(act_i), .act_chan_i(act_chan_i),
      .amp_settled_i(amp_settled_i), .busy_o(busy_o),
      .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
      .amp_warn_o(amp_warn_o), .irq_o(irq_o));
   sst_tank_model sst_tank_model_i (.clk_i(clk_i), .rst_i(rst_i),
      .drive_i(busy_o), .settle_cyc_i(settle_cyc),
      .amp_settled_o(amp_settled_i));

   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end

   // ==========================================================
   // Compare and bus tasks
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %0t value got %h exp %h", $time, g, e);
      end
   endtask : chk16

   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %0t flag got %b exp %b", $time, g, e);
      end
   endtask : chk1

   task automatic chkn(input int g, input int e);
      check_count++;
      if (g != e)
      begin
         bad_count++;
         $display("BAD %0t cycles got %0d exp %0d", $time, g, e);
      end
   endtask : chkn

   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk16(rdata_o, e);
   endtask : rd_chk

   // Write then read back with no idle cycle between the two strobes.
   task automatic wr_rd_chk(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk16(rdata_o, d);
   endtask : wr_rd_chk

   // ==========================================================
   // One settle sequence against the model; poke tries a count
   // rewrite and a second request while the wait runs.
   task automatic run(input int ch, input int cnt, input int dv,
         input int en, input logic [15:0] sc, input int poke);
      int t;
      int n;
      logic w;
      t = ((cnt <= 1) ? 32 : cnt * 16) * ((dv == 0) ? 1 : dv) + 1;
      w = (en != 0) && (sc == 16'hFFFF);
      cnt_m[ch] = cnt;
      last_ch = ch;
      wr(8'(sst_pkg::ADDR_STAB0 + ch), 16'(cnt));
      wr(8'(sst_pkg::ADDR_DIV0 + ch), 16'(dv));
      wr(sst_pkg::ADDR_CTRL, 16'(en));
      rd_chk(sst_pkg::ADDR_CTRL, 16'(en));
      @(posedge clk_i);
      settle_cyc <= sc;
      act_i <= 1'b1;
      act_chan_i <= 2'(ch);
      @(posedge clk_i);
      act_i <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
         if (poke != 0 && n == 2)
         begin
            addr_i <= 8'(sst_pkg::ADDR_STAB0 + ch);
            wdata_i <= 16'hFFFF;
            wr_i <= 1'b1;
            act_i <= 1'b1;
            act_chan_i <= 2'((ch + 1) % 3);
            cnt_m[ch] = 16'hFFFF;
         end
         else if (poke != 0 && n == 3)
         begin
            wr_i <= 1'b0;
            act_i <= 1'b0;
         end
         else if (poke != 0 && n == 4)
         begin
            addr_i <= sst_pkg::ADDR_STATE;
            rd_i <= 1'b1;
         end
         else if (poke != 0 && n == 5)
            rd_i <= 1'b0;
         #1;
         if (poke != 0 && n == 5)
            chk16(rdata_o, 16'(4 + ch));
         if (poke != 0 && n == 6)
            chk16(rdata_o, 16'h0000);
         if (n == 1 || n == t - 1)
            chk1(busy_o, 1'b1);
      end while (conv_start_o !== 1'b1 && n < t + 20);
      if (n >= t + 20)
      begin
         bad_count++;
         $display("BAD %0t conversion start never came", $time);
         report_and_stop();
      end
      chkn(n, t);
      chk1(busy_o, 1'b0);
      chk1(amp_warn_o, w);
      chk16(16'(conv_chan_o), 16'(ch));
      stat_m = w ? 3 : 1;
      @(posedge clk_i);
      #1 chk1(irq_o, (stat_m & mask_m) != 0);
      rd_chk(sst_pkg::ADDR_STAT, 16'(stat_m));
      wr(sst_pkg::ADDR_STAT, 16'h0003);
      stat_m = 0;
      #1 chk1(irq_o, 1'b0);
      if (poke != 0)
         rd_chk(8'(sst_pkg::ADDR_STAB0 + ch), 16'(cnt_m[ch]));
   endtask : run

   // ==========================================================
   // Main sequence
   initial
   begin
      int c;
      int r;
      logic [15:0] v;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (c = 0; c < 3; c++)
      begin
         rd_chk(8'(sst_pkg::ADDR_STAB0 + c), 16'h0000);
         rd_chk(8'(sst_pkg::ADDR_DIV0 + c), 16'h0000);
      end
      rd_chk(8'h30, 16'h0000);
      rd_chk(sst_pkg::ADDR_CTRL, 16'h0000);
      rd_chk(sst_pkg::ADDR_MASK, 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         v = 16'($random(seed));
         cnt_m[i % 3] = v;
         wr(8'(sst_pkg::ADDR_STAB0 + i % 3), v);
         for (c = 0; c < 3; c++)
            rd_chk(8'(sst_pkg::ADDR_STAB0 + c), 16'(cnt_m[c]));
      end
      v = 16'($random(seed));
      cnt_m[0] = v;
      wr_rd_chk(sst_pkg::ADDR_STAB0, v);
      wr(sst_pkg::ADDR_DIV0, 16'hFFFF);
      rd_chk(sst_pkg::ADDR_DIV0, 16'h03FF);
      wr(sst_pkg::ADDR_MASK, 16'h0001);
      mask_m = 1;
      rd_chk(sst_pkg::ADDR_MASK, 16'h0001);
      run(0, 0, 1, 1, 16'h0004, 0);
      run(1, 1, 0, 1, 16'hFFFF, 0);
      run(2, 2, 3, 0, 16'hFFFF, 1);
      wr(sst_pkg::ADDR_MASK, 16'h0002);
      mask_m = 2;
      run(0, 3, 2, 1, 16'hFFFF, 0);
      for (int i = 0; i < 4; i++)
      begin
         r = $random(seed);
         run({r} % 3, 2 + {r} / 3 % 40, 1 + {r} / 200 % 8, {r} / 5 % 2,
            ({r} / 7 % 2 != 0) ? 16'hFFFF : 16'h0004, 0);
      end
      @(posedge clk_i);
      act_i <= 1'b1;
      act_chan_i <= 2'h3;
      @(posedge clk_i);
      act_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk1(busy_o, 1'b0);
      rd_chk(sst_pkg::ADDR_STATE, 16'(last_ch));
      report_and_stop();
   end
endmodule : sst_settle_top_tb
